// ===== include/bit_ctl_pkg.sv
// Shared constants, opcodes and decode functions for the one-bit controller system
// Summary of operation
// - Clock phase selects opcode or operand word
// - Opcode latched at end of fetch phase
// - Four-bit memory addresses sixteen inputs, outputs
// - Eight-bit interleave gives 128-statement program
// - Selector drives data line except stores
// - Plain inputs at 1-7, plain outputs at 0-7
// - Readable latches at 8-15 both maps
// - Latches load on gated store only
// - Latch holds bit until re-addressed
// - Result bit read as input zero
// - Halt/run latch; outputs clear when halted
// - All-ones, all-zeros opcodes do nothing
// - Branch, return, null pulses are ignored
// - Opcode even location, operand next one
// - Operand of operandless opcode is ignored
// - Load 0001, and 0011, skip 1110, store 1000
// - One statement per fetch-execute cycle pair
// - Store drives result, asserts write strobe
// - Output gate zero suppresses write strobe
// - Counter steps each statement, clears on reset
package bit_ctl_pkg;
    localparam int NIB_W = 4;
    localparam int PC_W = 7;
    localparam int MEM_AW = 8;
    localparam int MEM_DEPTH = 256;
    localparam int LANE_N = 8;
    localparam int PIN_N = 10;
    localparam int BANK_BIT = 3;
    localparam int HALT_PIN = 9;
    localparam int RUN_PIN = 8;
    localparam logic [2:0] RESULT_IN_ADDR = 3'h0;
    localparam logic [PC_W-1:0] PC_RESET = 7'h00;
    localparam logic [LANE_N-1:0] OUT_RESET = 8'h00;
    localparam logic HALT_RESET = 1'b1;
    localparam logic GATE_RESET = 1'b0;
    localparam logic RESULT_RESET = 1'b0;

    typedef enum logic [3:0]
    {
        null_zero_instr = 4'h0,
        load_result_instr = 4'h1,
        load_compl_instr = 4'h2,
        and_instr = 4'h3,
        and_compl_instr = 4'h4,
        or_instr = 4'h5,
        or_compl_instr = 4'h6,
        xnor_instr = 4'h7,
        write_result_instr = 4'h8,
        write_complement_instr = 4'h9,
        input_gate_load_instr = 4'ha,
        output_gate_load_instr = 4'hb,
        branch_pulse_instr = 4'hc,
        return_pulse_instr = 4'hd,
        conditional_skip_instr = 4'he,
        null_ones_instr = 4'hf
    } opcode_type;

    typedef enum logic
    {
        phase_exec = 1'b0,
        phase_fetch = 1'b1
    } phase_type;

    function automatic logic is_store(input logic [NIB_W-1:0] op);
        return (op == write_result_instr) || (op == write_complement_instr);
    endfunction : is_store
endpackage : bit_ctl_pkg

// ===== include/bit_ctl_if.sv
// Link between the bit processor and its surrounding system logic
`timescale 1ns/1ps
interface bit_ctl_if
(
    input wire logic i_clk // System clock
);
    logic phase;
    logic [bit_ctl_pkg::NIB_W-1:0] mem_nibble;
    logic halt_reset;
    logic dev_data;
    logic dev_oe_n;
    logic sys_data;
    logic sys_oe_n;
    logic data_line;
    logic write_strobe;
    logic result_bit;
    logic [3:0] flag_pulse;

    // Shared data line, pulled low when nobody drives
    assign data_line = !dev_oe_n ? dev_data : (!sys_oe_n ? sys_data : 1'b0);

    modport processor
    (
        input phase, mem_nibble, halt_reset, data_line,
        output dev_data, dev_oe_n, write_strobe, result_bit, flag_pulse
    );
    modport system
    (
        input write_strobe, result_bit, data_line,
        output phase, mem_nibble, halt_reset, sys_data, sys_oe_n
    );
endinterface : bit_ctl_if

// ===== hw/bit_processor.sv
// One-bit processor end: opcode latch, result, gates, skip and write strobe
`timescale 1ns/1ps
module bit_processor
(
    input wire logic i_clk, // System clock
    input wire logic i_resetn, // Synchronous reset, active low
    bit_ctl_if.processor bus, // Link to system logic
    output logic o_result_bit, // Result register
    output logic o_input_gate, // Input gate register
    output logic o_output_gate, // Output gate register
    output logic [3:0] o_opcode // Latched opcode
);
    typedef struct packed
    {
        logic [bit_ctl_pkg::NIB_W-1:0] instr;
        logic result;
        logic input_gate_register;
        logic output_gate_register;
        logic skip;
    } proc_state_type;

    proc_state_type s;
    proc_state_type next_s;
    bit_ctl_pkg::opcode_type op;
    logic exec;
    logic din;

    assign op = bit_ctl_pkg::opcode_type'(s.instr);
    assign exec = (bus.phase == bit_ctl_pkg::phase_exec) && !bus.halt_reset && !s.skip;
    assign din = bus.data_line & s.input_gate_register;

    always_comb
    begin
        next_s = s;
        if (!i_resetn || bus.halt_reset)
        begin
            next_s.instr = bit_ctl_pkg::null_zero_instr;
            next_s.result = bit_ctl_pkg::RESULT_RESET;
            next_s.input_gate_register = bit_ctl_pkg::GATE_RESET;
            next_s.output_gate_register = bit_ctl_pkg::GATE_RESET;
            next_s.skip = 1'b0;
        end
        else if (bus.phase == bit_ctl_pkg::phase_fetch)
        begin
            next_s.instr = bus.mem_nibble;
        end
        else
        begin
            next_s.skip = 1'b0;
            if (!s.skip)
            begin
                case (op)
                    bit_ctl_pkg::load_result_instr: next_s.result = din;
                    bit_ctl_pkg::load_compl_instr: next_s.result = !din;
                    bit_ctl_pkg::and_instr: next_s.result = s.result & din;
                    bit_ctl_pkg::and_compl_instr: next_s.result = s.result & !din;
                    bit_ctl_pkg::or_instr: next_s.result = s.result | din;
                    bit_ctl_pkg::or_compl_instr: next_s.result = s.result | !din;
                    bit_ctl_pkg::xnor_instr: next_s.result = s.result ~^ din;
                    bit_ctl_pkg::input_gate_load_instr: next_s.input_gate_register = bus.data_line;
                    bit_ctl_pkg::output_gate_load_instr: next_s.output_gate_register = bus.data_line;
                    // Skip next statement when result is zero
                    bit_ctl_pkg::conditional_skip_instr: next_s.skip = !s.result;
                    default: next_s = next_s;
                endcase
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        s <= next_s;
    end

    assign bus.dev_oe_n = !(exec && bit_ctl_pkg::is_store(s.instr));
    assign bus.dev_data = (op == bit_ctl_pkg::write_complement_instr) ? !s.result : s.result;
    assign bus.write_strobe = exec && bit_ctl_pkg::is_store(s.instr) && s.output_gate_register;
    assign bus.result_bit = s.result;
    // One driver for the whole pulse vector
    assign bus.flag_pulse = {exec && (op == bit_ctl_pkg::null_ones_instr),
        exec && (op == bit_ctl_pkg::return_pulse_instr),
        exec && (op == bit_ctl_pkg::branch_pulse_instr),
        exec && (op == bit_ctl_pkg::null_zero_instr)};

    assign o_result_bit = s.result;
    assign o_input_gate = s.input_gate_register;
    assign o_output_gate = s.output_gate_register;
    assign o_opcode = s.instr;
endmodule : bit_processor

// ===== hw/bit_ctl_system.sv
// System end: interlaced program memory, counter, selectors, latches, halt/run
`timescale 1ns/1ps
module bit_ctl_system
(
    input wire logic i_clk, // System clock
    input wire logic i_resetn, // Synchronous reset, active low
    bit_ctl_if.system bus, // Link to processor
    input wire logic [7:0] i_inputs, // Plain input pins
    input wire logic i_run_press, // Momentary run control
    input wire logic i_halt_press, // Momentary halt control
    input wire logic i_load_we, // Program write strobe
    input wire logic [7:0] i_load_addr, // Program write address
    input wire logic [3:0] i_load_data, // Program write nibble
    output logic [7:0] o_outputs, // Write-only output latches
    output logic [7:0] o_storage, // Readable output latches
    output logic [6:0] o_pc, // Statement counter
    output logic o_halted, // Halt/run latch state
    output logic o_fetch_phase // High in opcode phase
);
    typedef struct packed
    {
        logic [bit_ctl_pkg::MEM_DEPTH-1:0][bit_ctl_pkg::NIB_W-1:0] mem;
        logic [bit_ctl_pkg::PC_W-1:0] pc;
        logic phase;
        logic halted;
        logic [bit_ctl_pkg::NIB_W-1:0] op_copy;
        logic [bit_ctl_pkg::PIN_N-1:0] sync1;
        logic [bit_ctl_pkg::PIN_N-1:0] sync2;
        logic [bit_ctl_pkg::PIN_N-1:0] sync3;
        logic [bit_ctl_pkg::PIN_N-1:0] pins;
        logic [bit_ctl_pkg::LANE_N-1:0] out_plain;
        logic [bit_ctl_pkg::LANE_N-1:0] out_store;
    } sys_state_type;

    sys_state_type s;
    sys_state_type next_s;
    logic [bit_ctl_pkg::MEM_AW-1:0] mem_addr;
    logic [bit_ctl_pkg::NIB_W-1:0] nibble;
    logic [2:0] lane;
    logic bank;
    logic sel_bit;
    logic exec;
    logic stable;

    assign mem_addr = {s.pc, ~s.phase};
    assign nibble = s.mem[mem_addr];
    // Bank bit plus lane, sixteen addresses
    assign lane = nibble[2:0];
    assign bank = nibble[bit_ctl_pkg::BANK_BIT];
    assign exec = (s.phase == bit_ctl_pkg::phase_exec) && !s.halted;

    // Input selector
    always_comb
    begin
        sel_bit = 1'b0;
        if (bank)
        begin
            sel_bit = s.out_store[lane];
        end
        else if (lane == bit_ctl_pkg::RESULT_IN_ADDR)
        begin
            sel_bit = bus.result_bit;
        end
        else
        begin
            sel_bit = s.pins[lane];
        end
    end

    always_comb
    begin
        next_s = s;
        stable = 1'b0;
        // Three-stage pin synchroniser
        next_s.sync1 = {i_halt_press, i_run_press, i_inputs};
        next_s.sync2 = s.sync1;
        next_s.sync3 = s.sync2;
        for (int i = 0; i < bit_ctl_pkg::PIN_N; i++)
        begin
            stable = (s.sync2[i] == s.sync3[i]);
            if (stable)
            begin
                next_s.pins[i] = s.sync3[i];
            end
        end

        if (s.pins[bit_ctl_pkg::HALT_PIN])
        begin
            next_s.halted = 1'b1;
        end
        else if (s.pins[bit_ctl_pkg::RUN_PIN])
        begin
            next_s.halted = 1'b0;
        end

        // Program loading only while halted
        if (i_load_we && s.halted)
        begin
            next_s.mem[i_load_addr] = i_load_data;
        end

        if (s.halted)
        begin
            next_s.out_plain = bit_ctl_pkg::OUT_RESET;
            next_s.out_store = bit_ctl_pkg::OUT_RESET;
            next_s.pc = bit_ctl_pkg::PC_RESET;
            next_s.phase = bit_ctl_pkg::phase_fetch;
            next_s.op_copy = bit_ctl_pkg::null_zero_instr;
        end
        else if (s.phase == bit_ctl_pkg::phase_fetch)
        begin
            next_s.op_copy = nibble;
            next_s.phase = bit_ctl_pkg::phase_exec;
        end
        else
        begin
            next_s.phase = bit_ctl_pkg::phase_fetch;
            next_s.pc = s.pc + 7'h01;
            if (bus.write_strobe)
            begin
                if (bank)
                begin
                    next_s.out_store[lane] = bus.data_line;
                end
                else
                begin
                    next_s.out_plain[lane] = bus.data_line;
                end
            end
        end

        if (!i_resetn)
        begin
            next_s = '0;
            next_s.halted = bit_ctl_pkg::HALT_RESET;
            next_s.phase = bit_ctl_pkg::phase_fetch;
            next_s.pc = bit_ctl_pkg::PC_RESET;
            next_s.out_plain = bit_ctl_pkg::OUT_RESET;
            next_s.out_store = bit_ctl_pkg::OUT_RESET;
        end
    end

    always_ff @(posedge i_clk)
    begin
        s <= next_s;
    end

    assign bus.phase = s.phase;
    assign bus.mem_nibble = nibble;
    assign bus.halt_reset = s.halted;
    assign bus.sys_oe_n = !(exec && !bit_ctl_pkg::is_store(s.op_copy));
    assign bus.sys_data = sel_bit;

    assign o_outputs = s.out_plain;
    assign o_storage = s.out_store;
    assign o_pc = s.pc;
    assign o_halted = s.halted;
    assign o_fetch_phase = s.phase;
endmodule : bit_ctl_system

// ===== test/bit_ctl_chk.sv
// Concurrent checks on the link between bit processor and system logic
`timescale 1ns/1ps
module bit_ctl_chk
(
    input wire logic i_clk, // System clock
    input wire logic i_resetn, // Synchronous reset, active low
    input wire logic phase, // Fetch or execute phase
    input wire logic [3:0] mem_nibble, // Addressed memory word
    input wire logic halt_reset, // Processor reset from halt latch
    input wire logic dev_oe_n, // Processor drive, low active
    input wire logic sys_oe_n, // Selector drive, low active
    input wire logic data_line, // Resolved data line
    input wire logic write_strobe, // Output write strobe
    input wire logic result_bit, // Result register
    input wire logic [3:0] flag_pulse // Ignored flag pulses
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    // Running fetch cycle followed by its execute cycle
    sequence s_statement;
        phase && !halt_reset ##1 !phase && !halt_reset;
    endsequence
    // Skip fetched with result zero, then next fetch
    sequence s_skip_taken;
        phase && !halt_reset && mem_nibble == bit_ctl_pkg::conditional_skip_instr && !result_bit
            ##1 !phase ##1 phase;
    endsequence

    a_phase_alternates: assert property
        (!halt_reset && !$past(halt_reset) |-> phase != $past(phase))
        else $error("phase did not alternate while running");
    a_halt_holds_fetch: assert property
        (halt_reset && $past(halt_reset) |-> phase)
        else $error("phase left fetch while halted");
    a_strobe_on_store: assert property
        (write_strobe |-> !phase && $past(phase) && !dev_oe_n
            && bit_ctl_pkg::is_store($past(mem_nibble)))
        else $error("write strobe outside a store execute cycle");
    a_store_data_value: assert property
        (s_statement ##0 (bit_ctl_pkg::is_store($past(mem_nibble)) && !dev_oe_n)
            |-> data_line == (result_bit
                != ($past(mem_nibble) == bit_ctl_pkg::write_complement_instr)))
        else $error("stored bit differs from result");
    a_selector_except_store: assert property
        (s_statement |-> sys_oe_n == bit_ctl_pkg::is_store($past(mem_nibble)))
        else $error("selector drive wrong in execute cycle");
    a_fetch_no_drive: assert property
        (phase |-> dev_oe_n && !write_strobe)
        else $error("processor drives line in fetch cycle");
    a_null_keeps_result: assert property
        (s_statement ##0 ($past(mem_nibble) == 4'h0 || $past(mem_nibble) == 4'hf)
            |=> halt_reset || result_bit == $past(result_bit))
        else $error("null opcode changed result");
    a_flag_one_cycle: assert property
        (flag_pulse != 4'h0 |-> !phase ##1 flag_pulse == 4'h0)
        else $error("flag pulse not a single execute cycle");
    a_skip_blocks_store: assert property
        (s_skip_taken |=> dev_oe_n && !write_strobe)
        else $error("skipped statement still acted");
    a_halt_silences: assert property
        (halt_reset |-> dev_oe_n && !write_strobe)
        else $error("halted processor still writes");
endmodule : bit_ctl_chk

// ===== test/testbench.sv
// Self-checking bench joining bit processor and system logic
`timescale 1ns/1ps
module testbench;
    localparam int TIME_LIMIT = 4000;
    localparam int PROG_N = 29;
    // Statements 14 on exercise the remaining logic opcodes and the ignored pulses
    localparam logic [7:0] PROG [PROG_N] = '{8'ha6, 8'hb6, 8'h12, 8'h31, 8'h87, 8'h99, 8'h19,
        8'h8a, 8'h10, 8'hef, 8'h83, 8'hb5, 8'h84, 8'hb6, 8'hff, 8'h25, 8'h81, 8'h46, 8'h92,
        8'h56, 8'h85, 8'h15, 8'h65, 8'h86, 8'h75, 8'h9b, 8'hc0, 8'hd0, 8'h9c};
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [7:0] inputs = 8'h00;
    logic run_press = 1'b0;
    logic halt_press = 1'b0;
    logic load_we = 1'b0;
    logic [7:0] load_addr = 8'h00;
    logic [3:0] load_data = 4'h0;
    logic [7:0] outputs;
    logic [7:0] storage;
    logic [6:0] pc;
    logic halted;
    logic fetch_phase;
    logic result_bit;
    logic input_gate;
    logic output_gate;
    logic [3:0] opcode;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;

    always #5 i_clk = ~i_clk;

    bit_ctl_if bus_if (.i_clk(i_clk));
    bit_processor bit_processor_inst (.i_clk(i_clk), .i_resetn(i_resetn), .bus(bus_if),
        .o_result_bit(result_bit), .o_input_gate(input_gate), .o_output_gate(output_gate),
        .o_opcode(opcode));
    bit_ctl_system bit_ctl_system_inst (.i_clk(i_clk), .i_resetn(i_resetn), .bus(bus_if),
        .i_inputs(inputs), .i_run_press(run_press), .i_halt_press(halt_press),
        .i_load_we(load_we), .i_load_addr(load_addr), .i_load_data(load_data),
        .o_outputs(outputs), .o_storage(storage), .o_pc(pc), .o_halted(halted),
        .o_fetch_phase(fetch_phase));
    bit_ctl_chk bit_ctl_chk_inst (.i_clk(i_clk), .i_resetn(i_resetn),
        .phase(bus_if.phase), .mem_nibble(bus_if.mem_nibble), .halt_reset(bus_if.halt_reset),
        .dev_oe_n(bus_if.dev_oe_n), .sys_oe_n(bus_if.sys_oe_n), .data_line(bus_if.data_line),
        .write_strobe(bus_if.write_strobe), .result_bit(bus_if.result_bit),
        .flag_pulse(bus_if.flag_pulse));

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick

    // Run press, then first statement steps fetch, execute, next count
    task automatic start_run();
        int n;
        n = 0;
        run_press = 1'b1;
        while (halted !== 1'b0 && n < 20)
        begin
            tick(1);
            n++;
        end
        run_press = 1'b0;
        check("pc at start", {1'b0, pc}, 8'h00);
        check("fetch at start", {7'h00, fetch_phase}, 8'h01);
        tick(1);
        check("execute phase", {7'h00, fetch_phase}, 8'h00);
        tick(1);
        check("pc after one statement", {1'b0, pc}, 8'h01);
        check("opcode latched", {4'h0, opcode}, {4'h0, PROG[0][7:4]});
        check("input gate loaded", {7'h00, input_gate}, 8'h01);
        check("output gate not yet", {7'h00, output_gate}, 8'h00);
        check("result untouched", {7'h00, result_bit}, 8'h00);
    endtask : start_run

    task automatic t_reset();
        check("halted after reset", {7'h00, halted}, 8'h01);
        check("pc after reset", {1'b0, pc}, 8'h00);
        check("outputs after reset", outputs, 8'h00);
        check("storage after reset", storage, 8'h00);
        $display("test reset done");
    endtask : t_reset

    // Opcode at even word, operand at the odd word after it
    task automatic t_load();
        for (int i = 0; i < PROG_N; i++)
        begin
            load_we = 1'b1;
            load_addr = 8'(2 * i);
            load_data = PROG[i][7:4];
            tick(1);
            load_addr = 8'(2 * i + 1);
            load_data = PROG[i][3:0];
            tick(1);
        end
        load_we = 1'b0;
        check("pc while loading", {1'b0, pc}, 8'h00);
        check("halted while loading", {7'h00, halted}, 8'h01);
        $display("test load done");
    endtask : t_load

    task automatic t_run_taken_skip();
        inputs = 8'h46;
        tick(8);
        start_run();
        tick(600);
        check("outputs run one", outputs, 8'he6);
        check("storage run one", storage, 8'h18);
        check("storage after pulses", {7'h00, storage[4]}, 8'h01);
        $display("test run one done");
    endtask : t_run_taken_skip

    task automatic t_halt();
        halt_press = 1'b1;
        tick(8);
        halt_press = 1'b0;
        check("halted after press", {7'h00, halted}, 8'h01);
        check("outputs cleared", outputs, 8'h00);
        check("storage cleared", storage, 8'h00);
        check("pc cleared", {1'b0, pc}, 8'h00);
        check("result cleared", {7'h00, result_bit}, 8'h00);
        check("gates cleared", {6'h00, input_gate, output_gate}, 8'h00);
        check("opcode cleared", {4'h0, opcode}, 8'h00);
        $display("test halt done");
    endtask : t_halt

    // Write while running must be ignored, else the store at 3 is lost
    task automatic t_run_gated();
        inputs = 8'h44;
        tick(8);
        start_run();
        load_we = 1'b1;
        load_addr = 8'h14;
        load_data = 4'h0;
        tick(1);
        load_we = 1'b0;
        tick(600);
        check("outputs run two", outputs, 8'h6e);
        check("storage run two", storage, 8'h1e);
        $display("test run two done");
    endtask : t_run_gated

    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == TIME_LIMIT)
        begin
            errors++;
            $display("timeout after %0d cycles", cycles);
            give_verdict();
        end
    end

    initial
    begin
        tick(12);
        i_resetn = 1'b1;
        tick(1);
        t_reset();
        t_load();
        t_run_taken_skip();
        t_halt();
        t_run_gated();
        t_halt();
        give_verdict();
    end
endmodule : testbench
